// File: hw/drs_regs.svh
// Purpose: Constants of the DDR SPI command and capture block
// Assumes: Link clock period of 160 ns
// Notes:   Included by the package and by the top module
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH
`define DRS_CMD_BITS     16
`define DRS_RESP_BITS    32
`define DRS_STREAM_BITS  16
`define DRS_REPEAT_COUNT 5'h1F
`define DRS_SCLK_HALF    2
`define DRS_CS_HIGH_NS   154
`define DRS_LINK_NS      160
`define DRS_MSB_CMD      15
`define DRS_LAST_EDGE    5'h1F
`define DRS_LAST_TOGGLE  5'h1E
`endif

// File: hw/drs_pkg.sv
// Purpose: Types of the DDR SPI command and capture block
// Assumes: drs_regs.svh for widths
// Notes:   States are link-domain only
`include "drs_regs.svh"
package drs_pkg;
    typedef enum logic [2:0] {
        DRS_IDLE  = 3'h0,
        DRS_LEAD  = 3'h1,
        DRS_SHIFT = 3'h2,
        DRS_TAIL  = 3'h3,
        DRS_GAP   = 3'h4
    } drs_state_t;

    typedef struct packed {
        logic [`DRS_STREAM_BITS-1:0] a;
        logic [`DRS_STREAM_BITS-1:0] b;
    } drs_stream_t;
endpackage

// File: hw/drs_host_receiver.sv
// Purpose: DDR SPI controller: 16-bit command out, 32-bit double-rate capture in
// Assumes: i_link_clk free running; chip drives MISO per serial clock edge
// Notes:   Frame logic on the link clock; command and streams on i_clk
`include "drs_regs.svh"
module drs_host_receiver
    import drs_pkg::*;
#(
    parameter int HALF        = `DRS_SCLK_HALF,
    parameter int START_DELAY = 2 * `DRS_SCLK_HALF
)(
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_link_clk,
    input  wire logic                        i_cmd_valid,
    input  wire logic [`DRS_CMD_BITS-1:0]    i_cmd_word,
    output logic                             o_cmd_ready,
    input  wire logic                        i_stream_ready,
    output logic                             o_stream_valid,
    output drs_stream_t                      o_stream,
    output logic [`DRS_RESP_BITS-1:0]        o_raw_word,
    output logic                             o_overrun,
    output logic                             o_cs_n,
    output logic                             o_sclk,
    output logic                             o_mosi,
    output logic                             o_sample_clk,
    input  wire logic                        i_miso
);
    localparam int CS_HIGH = (`DRS_CS_HIGH_NS + `DRS_LINK_NS - 1) / `DRS_LINK_NS;
    localparam int PW      = $clog2(HALF + 1);
    localparam int DW      = $clog2(START_DELAY + 2);
    localparam int GW      = $clog2(CS_HIGH + 2);

    ////////////////////////////////////////////////////////////////////////
    // Link reset and crossings
    logic                        lrst_m;
    logic                        lrst;
    logic                        req_tgl_reg;
    logic                        req_m;
    logic                        req_s;
    logic                        req_seen_reg;
    logic                        done_tgl_reg;
    logic                        done_m;
    logic                        done_s;
    logic                        done_prev;
    logic                        miso_m;
    logic                        miso_s;
    logic [`DRS_CMD_BITS-1:0]    cmd_reg;

    // Release is synchronous to the link clock, assertion is not
    always_ff @(posedge i_link_clk or posedge i_rst)
        if (i_rst)
        begin
            lrst_m <= 1'b1;
            lrst   <= 1'b1;
        end
        else
        begin
            lrst_m <= 1'b0;
            lrst   <= lrst_m;
        end

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
        begin
            req_m  <= 1'b0;
            req_s  <= 1'b0;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            req_m  <= req_tgl_reg;
            req_s  <= req_m;
            miso_m <= i_miso;
            miso_s <= miso_m;
        end

    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            done_m    <= 1'b0;
            done_s    <= 1'b0;
            done_prev <= 1'b0;
        end
        else
        begin
            done_m    <= done_tgl_reg;
            done_s    <= done_m;
            done_prev <= done_s;
        end

    ////////////////////////////////////////////////////////////////////////
    // Link frame: select, serial clock, MOSI
    drs_state_t                  state_reg;
    logic [PW-1:0]               ph_reg;
    logic [4:0]                  edge_reg;
    logic [GW-1:0]               gap_reg;
    logic [`DRS_CMD_BITS-1:0]    sh_reg;
    logic                        cap_full_reg;
    logic                        tick;
    logic                        start;

    assign tick  = (ph_reg == PW'(HALF - 1));
    assign start = (state_reg == DRS_IDLE) && (req_s != req_seen_reg);

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
            ph_reg <= '0;
        else if ((state_reg == DRS_LEAD || state_reg == DRS_SHIFT) && !tick)
            ph_reg <= ph_reg + PW'(1);
        else
            ph_reg <= '0;

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
        begin
            state_reg    <= DRS_IDLE;
            o_cs_n       <= 1'b1;
            o_sclk       <= 1'b0;
            o_mosi       <= 1'b0;
            edge_reg     <= 5'h00;
            gap_reg      <= '0;
            sh_reg       <= '0;
            req_seen_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                DRS_IDLE:
                    if (start)
                    begin
                        req_seen_reg <= req_s;
                        o_cs_n       <= 1'b0;
                        sh_reg       <= cmd_reg;
                        o_mosi       <= cmd_reg[`DRS_MSB_CMD];
                        state_reg    <= DRS_LEAD;
                    end
                DRS_LEAD:
                    if (tick)
                    begin
                        o_sclk    <= 1'b1;
                        edge_reg  <= 5'h00;
                        state_reg <= DRS_SHIFT;
                    end
                DRS_SHIFT:
                    if (tick)
                    begin
                        o_sclk   <= ~o_sclk;
                        edge_reg <= edge_reg + 5'h01;
                        if (o_sclk)
                        begin
                            sh_reg <= {sh_reg[`DRS_CMD_BITS-2:0], 1'b0};
                            o_mosi <= sh_reg[`DRS_CMD_BITS-2];
                        end
                        // First rise plus 31 toggles: 32 edges, SCLK ends low
                        if (edge_reg == `DRS_LAST_TOGGLE)
                            state_reg <= DRS_TAIL;
                    end
                DRS_TAIL:
                    // Select held until all 32 samples are in
                    if (cap_full_reg)
                    begin
                        o_cs_n       <= 1'b1;
                        o_mosi       <= 1'b0;
                        done_tgl_reg <= ~done_tgl_reg;
                        gap_reg      <= '0;
                        state_reg    <= DRS_GAP;
                    end
                DRS_GAP:
                    if (gap_reg == GW'(CS_HIGH - 1))
                        state_reg <= DRS_IDLE;
                    else
                        gap_reg <= gap_reg + GW'(1);
                default:
                    state_reg <= DRS_IDLE;
            endcase
        end

    ////////////////////////////////////////////////////////////////////////
    // Double-rate sample clock and capture
    logic                        gen_arm_reg;
    logic [DW-1:0]               dly_reg;
    logic [PW-1:0]               pp_reg;
    logic [4:0]                  rep_reg;
    logic [4:0]                  cnt_reg;
    logic [`DRS_RESP_BITS-1:0]   cap_reg;
    logic [`DRS_RESP_BITS-1:0]   raw_reg;

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
        begin
            gen_arm_reg  <= 1'b0;
            dly_reg      <= '0;
            pp_reg       <= '0;
            rep_reg      <= 5'h00;
            o_sample_clk <= 1'b0;
        end
        else if (start)
        begin
            gen_arm_reg  <= 1'b1;
            dly_reg      <= DW'(START_DELAY);
            pp_reg       <= '0;
            rep_reg      <= `DRS_REPEAT_COUNT;
            o_sample_clk <= 1'b0;
        end
        else if (gen_arm_reg && dly_reg != '0)
        begin
            dly_reg      <= dly_reg - DW'(1);
            o_sample_clk <= 1'b0;
        end
        else if (gen_arm_reg)
        begin
            o_sample_clk <= (pp_reg == '0);
            if (pp_reg == PW'(HALF - 1))
            begin
                pp_reg <= '0;
                if (rep_reg == 5'h00)
                    gen_arm_reg <= 1'b0;
                else
                    rep_reg <= rep_reg - 5'h01;
            end
            else
                pp_reg <= pp_reg + PW'(1);
        end
        else
            o_sample_clk <= 1'b0;

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
        begin
            cap_reg      <= '0;
            raw_reg      <= '0;
            cnt_reg      <= 5'h00;
            cap_full_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg      <= 5'h00;
            cap_full_reg <= 1'b0;
        end
        else if (o_sample_clk)
        begin
            cap_reg <= {cap_reg[`DRS_RESP_BITS-2:0], miso_s};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `DRS_LAST_EDGE)
            begin
                raw_reg      <= {cap_reg[`DRS_RESP_BITS-2:0], miso_s};
                cap_full_reg <= 1'b1;
            end
        end

    ////////////////////////////////////////////////////////////////////////
    // System side: command taking, de-interleave, overrun
    logic                        done_edge;
    assign done_edge = done_s ^ done_prev;

    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            o_cmd_ready <= 1'b1;
            req_tgl_reg <= 1'b0;
            cmd_reg     <= '0;
        end
        else if (i_cmd_valid && o_cmd_ready)
        begin
            cmd_reg     <= i_cmd_word;
            req_tgl_reg <= ~req_tgl_reg;
            o_cmd_ready <= 1'b0;
        end
        else if (done_edge)
            o_cmd_ready <= 1'b1;

    // One-cycle split, so it always ends before the next frame
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            o_stream_valid <= 1'b0;
            o_stream       <= '0;
            o_raw_word     <= '0;
            o_overrun      <= 1'b0;
        end
        else
        begin
            o_overrun <= done_edge && o_stream_valid && !i_stream_ready;
            if (done_edge)
            begin
                o_stream_valid <= 1'b1;
                o_raw_word     <= raw_reg;
                for (int i = 0; i < `DRS_STREAM_BITS; i++)
                begin
                    o_stream.a[i] <= raw_reg[2*i+1];
                    o_stream.b[i] <= raw_reg[2*i];
                end
            end
            else if (i_stream_ready)
                o_stream_valid <= 1'b0;
        end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [4:0] rise_cnt;
    logic       sclk_d;
    logic [7:0] since_cs;

    always_ff @(posedge i_link_clk or posedge lrst)
        if (lrst)
        begin
            rise_cnt <= 5'h00;
            sclk_d   <= 1'b0;
            since_cs <= 8'h00;
        end
        else
        begin
            sclk_d   <= o_sclk;
            since_cs <= start ? 8'h00 : since_cs + 8'h01;
            if (start)
                rise_cnt <= 5'h00;
            else if (o_sclk && !sclk_d)
                rise_cnt <= rise_cnt + 5'h01;
        end

    property p_frame_pulses;
        @(posedge i_link_clk) disable iff (lrst)
        $rose(o_cs_n) |-> rise_cnt == 5'h10 && cnt_reg == 5'h00 && cap_full_reg;
    endproperty
    a_frame_pulses: assert property (p_frame_pulses) else $error("frame pulse count wrong");

    property p_idle_clk;
        @(posedge i_link_clk) disable iff (lrst)
        o_cs_n |-> !o_sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("serial clock high while deselected");

    property p_first_sample;
        @(posedge i_link_clk) disable iff (lrst)
        o_sample_clk && cnt_reg == 5'h00 |-> rise_cnt == 5'h01 && !o_sclk;
    endproperty
    a_first_sample: assert property (p_first_sample) else $error("first sample not after first fall");

    property p_sample_spacing;
        @(posedge i_link_clk) disable iff (lrst)
        o_sample_clk && cnt_reg != `DRS_LAST_EDGE |-> ##2 o_sample_clk;
    endproperty
    a_sample_spacing: assert property (p_sample_spacing) else $error("sample pulses not at double rate");

    property p_start_delay;
        @(posedge i_link_clk) disable iff (lrst)
        o_sample_clk && cnt_reg == 5'h00 |-> since_cs == 8'(START_DELAY + 1);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("sample start delay wrong");

    property p_sample_framed;
        @(posedge i_link_clk) disable iff (lrst)
        o_sample_clk |-> !o_cs_n;
    endproperty
    a_sample_framed: assert property (p_sample_framed) else $error("sample outside select");

    property p_gen_start;
        @(posedge i_link_clk) disable iff (lrst)
        start |=> gen_arm_reg && rep_reg == `DRS_REPEAT_COUNT;
    endproperty
    a_gen_start: assert property (p_gen_start) else $error("generator not armed at select");

    property p_split;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_stream_valid) |-> o_stream.a[0] == o_raw_word[1] && o_stream.b[15] == o_raw_word[30];
    endproperty
    a_split: assert property (p_split) else $error("stream split wrong");

    property p_overrun;
        @(posedge i_clk) disable iff (i_rst)
        done_edge && o_stream_valid && !i_stream_ready |=> o_overrun && o_stream_valid;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    c_frame: cover property (@(posedge i_link_clk) disable iff (lrst) $rose(o_cs_n));
    c_stream: cover property (@(posedge i_clk) disable iff (i_rst) o_stream_valid && i_stream_ready);
    c_overrun: cover property (@(posedge i_clk) disable iff (i_rst) o_overrun);
endmodule

// File: verif/drs_chip_model.sv
// Purpose: Behavioural amplifier chip on the far side of the DDR SPI link
// Assumes: Mode 0 command capture, response bit changes on every SCLK edge
// Notes:   Released MISO shows the inverse of its last value
module drs_chip_model (
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_mosi,
    input  wire logic [31:0] i_resp,
    output logic             o_miso,
    output logic [15:0]      o_cmd,
    output int               o_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    int edge_cnt;
    initial
    begin
        o_miso   = 1'b0;
        o_cmd    = 16'h0000;
        o_rises  = 0;
        edge_cnt = 0;
    end
    ////////////////////////////////////////////////////////////////
    // Inverted on every select change, outside frames too, so never a stale bit
    // Counts restart only at select fall, so they survive until checked
    always @(i_cs_n)
    begin
        if (!i_cs_n)
        begin
            edge_cnt = 0;
            o_rises  = 0;
        end
        o_miso = ~o_miso;
    end
    // Bit 31 first, A and B bits alternate on every edge
    always @(i_sclk)
    begin
        if (!i_cs_n && edge_cnt < 32)
        begin
            if (i_sclk)
            begin
                o_cmd = {o_cmd[14:0], i_mosi};
                o_rises++;
            end
            o_miso = i_resp[31 - edge_cnt];
            edge_cnt++;
        end
    end
endmodule

// File: verif/tb_ddr_spi_host_receiver.sv
// Purpose: Self-checking bench of the DDR SPI command and capture block
// Assumes: Default HALF and START_DELAY, link clock 160 ns
// Notes:   Frame timing judged by a monitor on the link clock
module tb_ddr_spi_host_receiver;
    import drs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst, i_link_clk, i_cmd_valid, i_stream_ready, i_miso;
    logic [15:0] i_cmd_word;
    logic        o_cmd_ready, o_stream_valid, o_overrun, o_cs_n, o_sclk, o_mosi, o_sample_clk;
    drs_stream_t o_stream;
    logic [31:0] o_raw_word, resp_word;
    logic [15:0] chip_cmd;
    int          chip_rises, fails, compares, lcnt, pulses, first_gap, rises, rises_first;
    logic        cs_q, sclk_q, ovr_seen;
    drs_host_receiver dut (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_link_clk     (i_link_clk),
        .i_cmd_valid    (i_cmd_valid),
        .i_cmd_word     (i_cmd_word),
        .o_cmd_ready    (o_cmd_ready),
        .i_stream_ready (i_stream_ready),
        .o_stream_valid (o_stream_valid),
        .o_stream       (o_stream),
        .o_raw_word     (o_raw_word),
        .o_overrun      (o_overrun),
        .o_cs_n         (o_cs_n),
        .o_sclk         (o_sclk),
        .o_mosi         (o_mosi),
        .o_sample_clk   (o_sample_clk),
        .i_miso         (i_miso)
    );
    drs_chip_model chip (
        .i_cs_n  (o_cs_n),
        .i_sclk  (o_sclk),
        .i_mosi  (o_mosi),
        .i_resp  (resp_word),
        .o_miso  (i_miso),
        .o_cmd   (chip_cmd),
        .o_rises (chip_rises)
    );
    ////////////////////////////////////////////////////////////////
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Odd offset keeps the two clocks apart in phase
    initial
    begin
        i_link_clk = 1'b0;
        #7;
        forever #80 i_link_clk = ~i_link_clk;
    end
    // Link-side monitor: lcnt counts link cycles since select fell
    always @(posedge i_link_clk)
    begin
        if (cs_q && !o_cs_n)
        begin
            lcnt   = 0;
            pulses = 0;
            rises  = 0;
        end
        else
            lcnt++;
        if (!sclk_q && o_sclk)
            rises++;
        if (o_sample_clk)
        begin
            if (pulses == 0)
            begin
                first_gap   = lcnt;
                rises_first = rises;
            end
            pulses++;
        end
        cs_q   = o_cs_n;
        sclk_q = o_sclk;
    end
    always @(posedge i_clk)
        if (o_overrun === 1'b1)
            ovr_seen = 1'b1;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_ready;
        for (int n = 0; n < 1000 && o_cmd_ready !== 1'b1; n++)
            @(posedge i_clk);
        #1;
        if (o_cmd_ready !== 1'b1)
            chk(32'h0, 32'h1);
    endtask
    task automatic t_reset;
        chk({o_cs_n, o_sclk, o_mosi, o_sample_clk}, 32'h8);
        chk({o_cmd_ready, o_stream_valid, o_overrun}, 32'h4);
        chk(o_raw_word, 32'h0);
        chk(o_stream, 32'h0);
    endtask
    // One command, one 32-bit capture, split into A and B
    task automatic t_frame(input logic [15:0] c, input logic [31:0] r, input bit accept, input logic ovr);
        logic [15:0] ea, eb;
        for (int i = 0; i < 16; i++)
        begin
            ea[i] = r[2 * i + 1];
            eb[i] = r[2 * i];
        end
        ovr_seen  = 1'b0;
        resp_word = r;
        wait_ready();
        @(posedge i_clk);
        i_cmd_word  <= c;
        i_cmd_valid <= 1'b1;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(o_cmd_ready, 1'b0);
        wait_ready();
        chk(chip_cmd, c);
        chk(chip_rises, 16);
        chk(o_raw_word, r);
        chk(pulses, 32);
        chk(first_gap, 5);
        chk(rises_first, 1);
        chk(o_stream.a, ea);
        chk(o_stream.b, eb);
        chk(o_stream_valid, 1'b1);
        chk(ovr_seen, ovr);
        if (accept)
        begin
            @(posedge i_clk);
            i_stream_ready <= 1'b1;
            @(posedge i_clk);
            i_stream_ready <= 1'b0;
            #1;
            chk(o_stream_valid, 1'b0);
        end
    endtask
    // Second result lands while the first is still unread
    task automatic t_overrun;
        t_frame(16'h3FA5, 32'h5A3C96E1, 0, 1'b0);
        t_frame(16'hC35A, 32'hFFFF0000, 1, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {fails, compares, lcnt, pulses, first_gap, rises, rises_first} = '0;
        {cs_q, sclk_q, ovr_seen} = 3'h4;
        i_rst          = 1'b1;
        i_cmd_valid    = 1'b0;
        i_cmd_word     = 16'h0000;
        i_stream_ready = 1'b0;
        resp_word      = 32'h00000000;
        repeat (10) @(posedge i_clk);
        #1;
        t_reset();
        @(posedge i_clk);
        i_rst <= 1'b0;
        t_frame(16'h8001, 32'h80000001, 1, 1'b0);
        t_frame(16'h0000, 32'hAAAAAAAA, 1, 1'b0);
        t_frame(16'hFFFF, 32'h55555555, 1, 1'b0);
        t_overrun();
        print_verdict();
    end
    initial
    begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule
